// *** core/eft_pkg.sv ***
package eft_pkg;

    // Sample count and coverage fraction format (1.0 = 0x10000)
    localparam int NSAMP = 8;
    localparam int MASK_WORD_W = 32;
    localparam int COV_W = 17;
    localparam logic [COV_W-1:0] COV_ONE = 17'h10000;
    localparam logic [17:0] COV_ROUND = 18'h01000;
    localparam int COV_SHIFT = 13;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SCIS_ORG = 8'h04;
    localparam logic [7:0] ADDR_SCIS_SIZE = 8'h08;
    localparam logic [7:0] ADDR_COV_VAL = 8'h0c;
    localparam logic [7:0] ADDR_SMASK0 = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;

    // Control register bit positions
    localparam int CTRL_SCIS_EN = 0;
    localparam int CTRL_COV_EN = 1;
    localparam int CTRL_COV_INV = 2;
    localparam int CTRL_MASK_EN = 3;
    localparam int CTRL_MS_ONE = 4;
    localparam int CTRL_FBO = 5;
    localparam int CTRL_EARLY_EN = 6;
    localparam int CTRL_SHADER = 7;
    localparam int CTRL_W = 8;

    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
    localparam logic [31:0] SCIS_ORG_RST = 32'h0000_0000;
    localparam logic [COV_W-1:0] COV_VAL_RST = 17'h10000;
    localparam logic [MASK_WORD_W-1:0] SMASK_RST = 32'hffff_ffff;
    localparam logic [15:0] ZERO16 = 16'h0000;

    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
        logic [NSAMP-1:0] cov;
        logic owned;
    } eft_frag_in_t;

    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
        logic [NSAMP-1:0] cov;
        logic subset;
        logic early_ops;
        logic late_ops;
        logic shade_valid;
    } eft_frag_out_t;

endpackage

// *** core/eft_stage.sv ***
// Summary of operation
// R1: Rejected fragments never reach later stages.
// R2: Ownership, scissor, coverage, then early ops order.
// R3: Ownership and scissor checks always applied.
// R4: Unowned pixel fate set by window system.
// R5: Framebuffer object target always passes ownership.
// R6: Scissor passes only inside left/bottom rectangle.
// R7: Scissor disabled passes; disabled after reset.
// R8: Scissor left and bottom reset to zero.
// R9: Scissor size resets to window or zero.
// R10: Coverage steps skipped unless multisample present.
// R11: Coverage ANDed with optionally inverted fraction mask.
// R12: Finally coverage ANDed with sample gate bits.
// R13: Mask set bits proportional to fraction.
// R14: Mask pattern varies with window coordinates.
// R15: Written fraction clamped into unit interval.
// R16: Gate bit B of word M is sample 32M+B.
// R17: Early enabled: depth ops run before shading. Code also needs CTRL_SHADER set; without it, late ops.
// R18: Otherwise depth ops deferred after shading.
// R19: Early updates allowed for later-discarded fragments.
// R20: No shader means shading results undefined.
// R21: Upstream coverage marks only covered samples.
// R22: Valid/ready both sides, order preserved.
// R23: Zero-coverage fragments dropped.
module eft_stage (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    input wire logic i_ws_keep,
    input wire logic i_has_dfb,
    input wire logic [15:0] i_win_w,
    input wire logic [15:0] i_win_h,
    input wire logic i_valid,
    output logic o_ready,
    input wire eft_pkg::eft_frag_in_t i_frag,
    output logic o_valid,
    input wire logic i_ready,
    output eft_pkg::eft_frag_out_t o_frag
);
    import eft_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave state
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [CTRL_W-1:0] ctrl;
    logic [15:0] scis_left;
    logic [15:0] scis_bottom;
    logic [15:0] scis_w;
    logic [15:0] scis_h;
    logic [COV_W-1:0] cov_val;
    logic [MASK_WORD_W-1:0] smask0;
    logic [15:0] pass_cnt;
    logic [15:0] drop_cnt;
    logic [31:0] rdata;

    logic next_wr_pend;
    logic [7:0] next_wr_addr;
    logic [CTRL_W-1:0] next_ctrl;
    logic [15:0] next_scis_left;
    logic [15:0] next_scis_bottom;
    logic [15:0] next_scis_w;
    logic [15:0] next_scis_h;
    logic [COV_W-1:0] next_cov_val;
    logic [MASK_WORD_W-1:0] next_smask0;
    logic [31:0] next_rdata;
    logic addr_ph;
    logic wr_act;

    // Zero wait states, so a single OKAY answer always suffices
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_hrdata = rdata;
    assign addr_ph = i_hsel && i_htrans[1] && i_hready;
    assign wr_act = wr_pend;

    // Address phase capture, read data and register writes
    always_comb begin
        next_wr_pend = addr_ph && i_hwrite;
        next_wr_addr = addr_ph ? i_haddr[7:0] : wr_addr;
        next_rdata = rdata;
        if (addr_ph && !i_hwrite) begin
            case (i_haddr[7:0])
                ADDR_CTRL: next_rdata = {24'h000000, ctrl};
                ADDR_SCIS_ORG: next_rdata = {scis_bottom, scis_left};
                ADDR_SCIS_SIZE: next_rdata = {scis_h, scis_w};
                ADDR_COV_VAL: next_rdata = {15'h0000, cov_val};
                ADDR_SMASK0: next_rdata = smask0;
                ADDR_STATUS: next_rdata = {drop_cnt, pass_cnt};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
        next_ctrl = ctrl;
        next_scis_left = scis_left;
        next_scis_bottom = scis_bottom;
        next_scis_w = scis_w;
        next_scis_h = scis_h;
        next_cov_val = cov_val;
        next_smask0 = smask0;
        if (wr_act) begin
            case (wr_addr)
                ADDR_CTRL: next_ctrl = i_hwdata[CTRL_W-1:0];
                ADDR_SCIS_ORG: begin
                    next_scis_left = i_hwdata[15:0];
                    next_scis_bottom = i_hwdata[31:16];
                end
                ADDR_SCIS_SIZE: begin
                    next_scis_w = i_hwdata[15:0];
                    next_scis_h = i_hwdata[31:16];
                end
                ADDR_COV_VAL: begin
                    // Signed 16.16 value clamped to [0, 1] [R15]
                    if (i_hwdata[31]) begin
                        next_cov_val = '0;
                    end else if (i_hwdata[30:0] > 31'(COV_ONE)) begin
                        next_cov_val = COV_ONE;
                    end else begin
                        next_cov_val = i_hwdata[COV_W-1:0];
                    end
                end
                ADDR_SMASK0: next_smask0 = i_hwdata;
                default: next_ctrl = ctrl;
            endcase
        end
    end

    // Scissor size loads the window size at reset, zero without one
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            rdata <= 32'h0000_0000;
            ctrl <= CTRL_RST; // Scissor off after reset [R7]
            scis_left <= SCIS_ORG_RST[15:0]; // [R8]
            scis_bottom <= SCIS_ORG_RST[31:16]; // [R8]
            scis_w <= i_has_dfb ? i_win_w : ZERO16; // [R9]
            scis_h <= i_has_dfb ? i_win_h : ZERO16; // [R9]
            cov_val <= COV_VAL_RST;
            smask0 <= SMASK_RST;
        end else begin
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            rdata <= next_rdata;
            ctrl <= next_ctrl;
            scis_left <= next_scis_left;
            scis_bottom <= next_scis_bottom;
            scis_w <= next_scis_w;
            scis_h <= next_scis_h;
            cov_val <= next_cov_val;
            smask0 <= next_smask0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Early test pipeline
    logic own_ok;
    logic own_subset;
    logic scis_ok;
    logic [16:0] x_end;
    logic [16:0] y_end;
    logic [17:0] cov_sum;
    logic [3:0] cov_bits;
    logic [2:0] rot;
    logic [NSAMP-1:0] tmp_mask;
    logic [NSAMP-1:0] gate_mask;
    logic [NSAMP-1:0] cov_a;
    logic [NSAMP-1:0] cov_b;
    logic [NSAMP-1:0] cov_fin;
    logic frag_pass;
    logic take;
    logic next_o_valid;
    eft_frag_out_t next_o_frag;
    logic [15:0] next_pass_cnt;
    logic [15:0] next_drop_cnt;

    // Ownership: framebuffer objects always own their pixels
    always_comb begin
        own_ok = 1'b1;
        own_subset = 1'b0;
        if (!ctrl[CTRL_FBO] && !i_frag.owned) begin // [R5] [R3]
            own_ok = i_ws_keep; // Window system decides [R4]
            own_subset = i_ws_keep;
        end
    end

    // Scissor rectangle, sums widened so edges never wrap
    assign x_end = {1'b0, scis_left} + {1'b0, scis_w};
    assign y_end = {1'b0, scis_bottom} + {1'b0, scis_h};
    assign scis_ok = !ctrl[CTRL_SCIS_EN] // [R7] [R3]
        || ({1'b0, i_frag.x} >= {1'b0, scis_left}
        && {1'b0, i_frag.x} < x_end
        && {1'b0, i_frag.y} >= {1'b0, scis_bottom}
        && {1'b0, i_frag.y} < y_end); // [R6]

    // Fraction to bit count, rounded: 1.0 gives all, 0.0 none
    assign cov_sum = {1'b0, cov_val} + COV_ROUND;
    assign cov_bits = cov_sum[COV_SHIFT+3:COV_SHIFT]; // [R13]
    // Window-relative hash keeps results invariant to window moves
    assign rot = i_frag.x[2:0] ^ {i_frag.y[1:0], i_frag.y[2]}; // [R14]

    // Per-sample thermometer mask rotated by the hash, plus gate bits
    for (genvar s = 0; s < NSAMP; s++) begin : g_samp
        logic [2:0] pos;
        assign pos = 3'(s) + rot;
        assign tmp_mask[s] = ({1'b0, pos} < cov_bits); // [R13]
        // Sample s lives in word s/32, bit s%32 [R16]
        assign gate_mask[s] = smask0[s % MASK_WORD_W];
    end

    // Coverage steps in order, skipped without multisampling
    always_comb begin
        cov_a = i_frag.cov;
        cov_b = i_frag.cov;
        cov_fin = i_frag.cov;
        if (ctrl[CTRL_MS_ONE]) begin // [R10]
            if (ctrl[CTRL_COV_EN]) begin
                cov_a = i_frag.cov & (ctrl[CTRL_COV_INV] ?
                    ~tmp_mask : tmp_mask); // [R11]
            end
            cov_b = cov_a;
            if (ctrl[CTRL_MASK_EN]) begin
                cov_b = cov_a & gate_mask; // [R12]
            end
            cov_fin = cov_b;
        end
    end

    // Ownership then scissor then coverage; any failure drops [R2]
    assign frag_pass = own_ok && scis_ok && (cov_fin != '0); // [R1] [R23]

    // One output register; input stalls only while it is full [R22]
    assign o_ready = !o_valid || i_ready;
    assign take = i_valid && o_ready;

    always_comb begin
        next_o_valid = o_valid;
        next_o_frag = o_frag;
        next_pass_cnt = pass_cnt;
        next_drop_cnt = drop_cnt;
        if (o_valid && i_ready) begin
            next_o_valid = 1'b0;
        end
        if (take) begin
            if (frag_pass) begin
                next_o_valid = 1'b1; // [R1] [R22]
                next_o_frag.x = i_frag.x;
                next_o_frag.y = i_frag.y;
                next_o_frag.cov = cov_fin; // [R12]
                next_o_frag.subset = own_subset; // [R4]
                // Depth ops before shading only with early tests on
                next_o_frag.early_ops = ctrl[CTRL_EARLY_EN]
                    && ctrl[CTRL_SHADER]; // [R17] [R19]
                next_o_frag.late_ops = !(ctrl[CTRL_EARLY_EN]
                    && ctrl[CTRL_SHADER]); // [R18]
                // No shader: downstream treats results as undefined
                next_o_frag.shade_valid = ctrl[CTRL_SHADER]; // [R20]
                next_pass_cnt = pass_cnt + 16'h0001;
            end else begin
                next_drop_cnt = drop_cnt + 16'h0001; // [R1]
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_valid <= 1'b0;
            o_frag <= '0;
            pass_cnt <= 16'h0000;
            drop_cnt <= 16'h0000;
        end else begin
            o_valid <= next_o_valid;
            o_frag <= next_o_frag;
            pass_cnt <= next_pass_cnt;
            drop_cnt <= next_drop_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    a_drop_unowned: assert property (take && !i_frag.owned // [R4]
        && !ctrl[CTRL_FBO] && !i_ws_keep
        |=> pass_cnt == $past(pass_cnt))
        else $error("unowned fragment forwarded");

    a_fbo_owns: assert property (take && ctrl[CTRL_FBO] // [R5]
        && !ctrl[CTRL_SCIS_EN] && !ctrl[CTRL_MS_ONE]
        && i_frag.cov != '0
        |=> pass_cnt == $past(pass_cnt) + 16'h0001)
        else $error("fbo fragment not forwarded");

    a_scissor_left: assert property (take && ctrl[CTRL_SCIS_EN] // [R6]
        && i_frag.x < scis_left |=> pass_cnt == $past(pass_cnt))
        else $error("fragment left of scissor forwarded");

    a_cov_bypass: assert property (take && frag_pass // [R10]
        && !ctrl[CTRL_MS_ONE] |=> o_frag.cov == $past(i_frag.cov))
        else $error("coverage changed without multisampling");

    a_cov_clamp: assert property (wr_act && wr_addr == ADDR_COV_VAL // [R15]
        && i_hwdata[31] |=> cov_val == '0)
        else $error("negative fraction not clamped");

    a_mask_gate: assert property (take && frag_pass // [R12]
        && ctrl[CTRL_MS_ONE] && ctrl[CTRL_MASK_EN]
        |=> (o_frag.cov & ~$past(gate_mask)) == '0)
        else $error("gated sample forwarded");

    a_early_flag: assert property (take && frag_pass // [R17]
        |=> o_frag.early_ops == $past(ctrl[CTRL_EARLY_EN]
        && ctrl[CTRL_SHADER]) && o_frag.late_ops == !o_frag.early_ops)
        else $error("early/late operation flags wrong");

    a_hold_stall: assert property (o_valid && !i_ready // [R22]
        |=> o_valid && $stable(o_frag))
        else $error("output changed while stalled");

    a_zero_drop: assert property (o_valid |-> o_frag.cov != '0) // [R23]
        else $error("zero coverage fragment forwarded");

    c_forward: cover property (take && frag_pass ##1 o_valid && i_ready);
    c_drop: cover property (take && !frag_pass);
    c_stall: cover property (o_valid && !i_ready ##1 o_valid && i_ready);

endmodule

// *** dv/eft_shader_sink.sv ***
module eft_shader_sink (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_stall,
    output logic o_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cnt;
    logic [1:0] next_cnt;
    // Slot counter: a busy shader takes one fragment in three
    always_comb begin
        next_cnt = (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
    end
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            cnt <= 2'h0;
        end else begin
            cnt <= next_cnt;
        end
    end
    // Ready follows i_stall combinationally; while stalled it is high only in slot zero
    assign o_ready = !i_stall || (cnt == 2'h0);
endmodule

// *** dv/eft_stage_test.sv ***
module eft_stage_test;
    timeunit 1ns;
    timeprecision 1ns;
    import eft_pkg::*;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [3:0] x;
        logic [3:0] y;
        logic [7:0] cov;
        logic [2:0] ows;
        logic [7:0] ecov;
    } eft_row_t;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic valid = 1'b0;
    logic ws_keep = 1'b0;
    logic has_dfb = 1'b1;
    logic stall = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hreadyout;
    logic hresp;
    logic o_rdy;
    logic o_vld;
    logic sink_rdy;
    logic [31:0] hrdata;
    logic [31:0] rd;
    eft_frag_in_t frag = '0;
    eft_frag_out_t ofrag;
    eft_frag_out_t exp_q[$];
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;
    int n_pass = 0;
    int n_drop = 0;
    // Rows: ctrl, x, y, cov in, {owned, ws_keep, pass}, cov out
    eft_row_t rows[20] = '{
        '{8'h00,4'h0,4'h0,8'hff,3'b101,8'hff},
        '{8'h01,4'h0,4'h0,8'hff,3'b100,8'h00},
        '{8'h01,4'h4,4'h2,8'hff,3'b101,8'hff},
        '{8'h01,4'hb,4'h5,8'hff,3'b101,8'hff},
        '{8'h01,4'hc,4'h5,8'hff,3'b100,8'h00},
        '{8'h01,4'hb,4'h6,8'hff,3'b100,8'h00},
        '{8'h00,4'h4,4'h2,8'hff,3'b000,8'h00},
        '{8'h00,4'h4,4'h2,8'hff,3'b011,8'hff},
        '{8'h20,4'h4,4'h2,8'hff,3'b001,8'hff},
        '{8'h02,4'h4,4'h2,8'hff,3'b101,8'hff},
        '{8'h12,4'h4,4'h2,8'hff,3'b101,8'h0f},
        '{8'h16,4'h4,4'h2,8'hff,3'b101,8'hf0},
        '{8'h12,4'h5,4'h2,8'hff,3'b101,8'h87},
        '{8'h1a,4'h4,4'h2,8'hff,3'b101,8'h0c},
        '{8'h18,4'h4,4'h2,8'hff,3'b101,8'h3c},
        '{8'h12,4'h4,4'h2,8'hc0,3'b100,8'h00},
        '{8'hc0,4'h4,4'h2,8'hff,3'b101,8'hff},
        '{8'h40,4'h4,4'h2,8'hff,3'b101,8'hff},
        '{8'hc1,4'h0,4'h0,8'hff,3'b100,8'h00},
        '{8'h80,4'h4,4'h2,8'hff,3'b101,8'hff}
    };

    eft_stage dut (
        .i_clk(clk), .i_rstn(rstn), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(hreadyout), .o_hreadyout(hreadyout),
        .o_hresp(hresp), .o_hrdata(hrdata), .i_ws_keep(ws_keep),
        .i_has_dfb(has_dfb), .i_win_w(16'h0140), .i_win_h(16'h00f0),
        .i_valid(valid), .o_ready(o_rdy), .i_frag(frag), .o_valid(o_vld),
        .i_ready(sink_rdy), .o_frag(ofrag)
    );
    eft_shader_sink sink (
        .i_clk(clk), .i_rstn(rstn), .i_stall(stall), .o_ready(sink_rdy)
    );

    ////////////////////////////////////////////////////////////////
    always #50 clk = !clk;

    task automatic chk32(input string n, input logic [31:0] e,
                         input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic chkf(input eft_frag_out_t e, input eft_frag_out_t g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH o_frag exp %h got %h", e, g);
        end
    endtask

    task report_and_stop;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Select stays up; idle htrans alone marks the gaps between transfers
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    // Push the expectation first; the monitor pops it on delivery
    task automatic drive(input eft_row_t r);
        eft_frag_out_t e;
        e = '{{12'h000, r.x}, {12'h000, r.y}, r.ecov,
              !r.ctrl[CTRL_FBO] && !r.ows[2],
              r.ctrl[CTRL_EARLY_EN] && r.ctrl[CTRL_SHADER],
              !(r.ctrl[CTRL_EARLY_EN] && r.ctrl[CTRL_SHADER]),
              r.ctrl[CTRL_SHADER]};
        if (r.ows[0]) begin
            exp_q.push_back(e);
            n_pass++;
        end else begin
            n_drop++;
        end
        ws_keep <= r.ows[1];
        frag <= '{{12'h000, r.x}, {12'h000, r.y}, r.cov, r.ows[2]};
        valid <= 1'b1;
        do @(posedge clk); while (o_rdy !== 1'b1);
    endtask

    task automatic run(input eft_row_t r);
        ahb(1'b1, ADDR_CTRL, {24'h000000, r.ctrl}, rd);
        drive(r);
        valid <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // Every delivered fragment must be the next expected one, in order
    always @(posedge clk) begin
        cycles++;
        if (o_vld === 1'b1 && sink_rdy === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk32("unexpected fragment", 32'h0, 32'h1);
            end else begin
                chkf(exp_q.pop_front(), ofrag);
            end
        end
        if (cycles == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk32("o_valid", 32'h0, {31'h0, o_vld});
        ahb(1'b0, ADDR_CTRL, 32'h0, rd);
        chk32("ctrl", 32'h0, rd);
        chk32("hresp", 32'h0, {31'h0, hresp});
        ahb(1'b0, ADDR_SCIS_ORG, 32'h0, rd);
        chk32("scis_org", SCIS_ORG_RST, rd);
        ahb(1'b0, ADDR_SCIS_SIZE, 32'h0, rd);
        chk32("scis_size", 32'h00f0_0140, rd);
        ahb(1'b0, ADDR_COV_VAL, 32'h0, rd);
        chk32("cov_val", 32'h0001_0000, rd);
        ahb(1'b0, ADDR_SMASK0, 32'h0, rd);
        chk32("smask0", 32'hffff_ffff, rd);
        $display("test reset_values done");
        // Scissor x 4..11, y 2..5; half coverage; gate keeps samples 2..5
        ahb(1'b1, ADDR_SCIS_ORG, 32'h0002_0004, rd);
        ahb(1'b1, ADDR_SCIS_SIZE, 32'h0004_0008, rd);
        ahb(1'b1, ADDR_COV_VAL, 32'h0000_8000, rd);
        ahb(1'b1, ADDR_SMASK0, 32'hffff_ff3c, rd);
        for (int i = 0; i < 20; i++) begin
            run(rows[i]);
        end
        $display("test table done");
        // Out-of-range fractions clamp to the ends of the unit interval
        ahb(1'b1, ADDR_COV_VAL, 32'h0002_0000, rd);
        ahb(1'b0, ADDR_COV_VAL, 32'h0, rd);
        chk32("cov_val high", 32'h0001_0000, rd);
        run(eft_row_t'{8'h12,4'h4,4'h2,8'hff,3'b101,8'hff});
        ahb(1'b1, ADDR_COV_VAL, 32'hffff_0000, rd);
        ahb(1'b0, ADDR_COV_VAL, 32'h0, rd);
        chk32("cov_val low", 32'h0, rd);
        run(eft_row_t'{8'h12,4'h4,4'h2,8'hff,3'b100,8'h00});
        $display("test clamp done");
        // Back-to-back stream into a stalling shader, one drop inside
        ahb(1'b1, ADDR_CTRL, 32'h0, rd);
        stall <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            drive(eft_row_t'{8'h00, i[3:0], 4'h1, 8'h01 << i,
                {i != 3, 1'b0, i != 3}, 8'h01 << i});
        end
        valid <= 1'b0;
        repeat (30) @(posedge clk);
        stall <= 1'b0;
        chk32("pending", 32'h0, 32'(exp_q.size()));
        $display("test stream done");
        ahb(1'b1, 8'h20, 32'hdead_beef, rd);
        ahb(1'b0, 8'h20, 32'h0, rd);
        chk32("unmapped", 32'h0, rd);
        ahb(1'b1, ADDR_STATUS, 32'h1234_5678, rd);
        ahb(1'b0, ADDR_STATUS, 32'h0, rd);
        chk32("status", {n_drop[15:0], n_pass[15:0]}, rd);
        $display("test registers done");
        // Second reset without a default framebuffer: size goes to zero
        has_dfb <= 1'b0;
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        ahb(1'b0, ADDR_SCIS_SIZE, 32'h0, rd);
        chk32("scis_size nodfb", 32'h0, rd);
        ahb(1'b0, ADDR_CTRL, 32'h0, rd);
        chk32("ctrl again", 32'h0, rd);
        $display("test second_reset done");
        report_and_stop();
    end
endmodule
